// File: ovsp_top.v
// Overvoltage stage pick-up: four stages, Avalon-MM register slave.
// Assumes voltage magnitudes come from logic on I_CLK in 0.01 %Un units.
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "ovsp_regs.vh"

module ovsp_top #(
    parameter TICK_CYCLES = `OVSP_TICK_US * `OVSP_CLK_MHZ,
    parameter MW          = 16
) (
    input  wire          I_CLK,             // 250 MHz clock
    input  wire          I_RST_B,           // Async reset, active low
    input  wire [7:0]    I_AVS_ADDRESS,     // Byte address
    input  wire          I_AVS_READ,        // Read request
    input  wire          I_AVS_WRITE,       // Write request
    input  wire [31:0]   I_AVS_WRITEDATA,   // Write data
    input  wire [3:0]    I_AVS_BYTEENABLE,  // Byte lanes
    output reg  [31:0]   O_AVS_READDATA,    // Read data
    output reg           O_AVS_WAITREQUEST, // Stall
    input  wire [MW-1:0] I_UL12,            // Line 1-2 magnitude
    input  wire [MW-1:0] I_UL23,            // Line 2-3 magnitude
    input  wire [MW-1:0] I_UL31,            // Line 3-1 magnitude
    input  wire [MW-1:0] I_UL1,             // Phase 1 magnitude
    input  wire [MW-1:0] I_UL2,             // Phase 2 magnitude
    input  wire [MW-1:0] I_UL3,             // Phase 3 magnitude
    input  wire [MW-1:0] I_UCH3,            // Channel 3 magnitude
    input  wire [MW-1:0] I_UCH4,            // Channel 4 magnitude
    output reg  [3:0]    O_PICKUP,          // Pick-up per stage
    output reg  [3:0]    O_START,           // Start per stage
    output reg  [3:0]    O_TRIP,            // Forced trip per stage
    output reg  [3:0]    O_BLOCKED,         // Blocked per stage
    output reg  [3:0]    O_TEST,            // Test mode per stage
    output reg           O_IRQ              // Interrupt level
);

    localparam [20:0] TICK_LAST = TICK_CYCLES - 1;
    localparam [3:0]  RAT_LAST  = 4'hB;

    // Register storage
    reg  [3:0]    gctrl;
    reg  [6:0]    cfg   [0:3];
    reg  [17:0]   grp0  [0:3];
    reg  [17:0]   grp1  [0:3];
    reg  [16:0]   ratio [0:11];
    reg  [7:0]    irq_stat;
    reg  [7:0]    irq_en;

    // Evaluation timing
    reg  [20:0]   tick_cnt;
    reg  [2:0]    ph;

    // Sampled magnitudes
    reg  [MW-1:0] m12, m23, m31, m1, m2, m3, mc3, mc4;

    // Stage results and history
    wire [3:0]    next_pick, next_start, next_trip, next_blk, next_test;
    reg  [3:0]    pick_d, blk_d;
    wire [12*MW-1:0] sel_flat;
    wire [4*MW-1:0]  lev_flat;

    // Ratio sequencer
    reg  [3:0]    ridx;
    reg           rbusy;
    reg           div_go;
    wire          div_done;
    wire [23:0]   div_quo;
    wire [1:0]    rstage;
    wire [MW-1:0] rmag;
    wire [MW-1:0] rlev;
    wire [23:0]   rnum;

    // Bus decode
    wire [7:0]    a;
    wire [2:0]    blk;
    wire [2:0]    sdiff;
    wire [1:0]    s;
    wire [2:0]    w;
    wire          is_stg;
    wire          wr_acc;
    wire [3:0]    rix;
    wire [31:0]   cfg_wm;
    wire [31:0]   grp0_wm;
    wire [31:0]   grp1_wm;
    reg  [31:0]   rd_next;
    wire [7:0]    clr_mask;
    wire [7:0]    ev_set;
    wire [7:0]    next_irq_stat;
    integer       i;
    integer       j;

    // Byte-lane merge of write data into a word
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                be_merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
            end
        end
    endfunction

    // Five-millisecond evaluation pulse and its pipeline stages
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            tick_cnt <= 21'h000000;
            ph       <= 3'h0;
        end else begin
            ph <= {ph[1:0], (tick_cnt == TICK_LAST)};
            if (tick_cnt == TICK_LAST) begin
                tick_cnt <= 21'h000000;
            end else begin
                tick_cnt <= tick_cnt + 21'h000001;
            end
        end
    end

    // Snapshot of fundamental-frequency magnitudes at each evaluation
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            m12 <= {MW{1'b0}};
            m23 <= {MW{1'b0}};
            m31 <= {MW{1'b0}};
            m1  <= {MW{1'b0}};
            m2  <= {MW{1'b0}};
            m3  <= {MW{1'b0}};
            mc3 <= {MW{1'b0}};
            mc4 <= {MW{1'b0}};
        end else if (ph[0]) begin
            m12 <= I_UL12;
            m23 <= I_UL23;
            m31 <= I_UL31;
            m1  <= I_UL1;
            m2  <= I_UL2;
            m3  <= I_UL3;
            mc3 <= I_UCH3;
            mc4 <= I_UCH4;
        end
    end

    // Per-stage selection, comparison and status decisions
    genvar g, v;
    generate
        for (g = 0; g < 4; g = g + 1) begin : stg
            wire [1:0]    src;
            wire [2:0]    mode_cfg;
            wire [2:0]    mode;
            wire [1:0]    force_sel;
            wire [17:0]   grp;
            wire [MW-1:0] level;
            wire [1:0]    opm;
            wire          two;
            wire          single;
            wire          off;
            wire          forced;
            wire          blk_mode;
            wire [2:0]    exc;
            wire [1:0]    cnt;
            wire [1:0]    need;
            wire          pick_now;
            reg  [3*MW-1:0] sel;

            assign src       = cfg[g][`OVSP_C_SRC_LSB +: 2];
            assign mode_cfg  = cfg[g][`OVSP_C_MODE_LSB +: 3];
            assign force_sel = cfg[g][`OVSP_C_FORCE_LSB +: 2];
            assign two       = gctrl[`OVSP_G_TWO_LINE];

            // Mode only honoured when individual setting is allowed
            assign mode = (gctrl[`OVSP_G_ALLOW_MODE] && mode_cfg <= `OVSP_MODE_OFF) ?
                          mode_cfg : `OVSP_MODE_ON;
            assign off      = (mode == `OVSP_MODE_OFF);
            assign blk_mode = (mode == `OVSP_MODE_BLOCKED) || (mode == `OVSP_MODE_TESTBLK);
            assign forced   = gctrl[`OVSP_G_FORCE_EN] &&
                              (force_sel != `OVSP_FORCE_NORMAL);

            // Active group supplies level and operation mode
            assign grp   = gctrl[`OVSP_G_GROUP] ? grp1[g] : grp0[g];
            assign level = grp[`OVSP_P_LEVEL_LSB +: MW];
            assign opm   = grp[`OVSP_P_OPM_LSB +: 2];

            // Source selection into three supervised voltages
            always @* begin
                case (src)
                    `OVSP_SRC_PP: begin
                        sel = {(two ? {MW{1'b0}} : m31), m23, m12};
                    end
                    `OVSP_SRC_PE: begin
                        sel = {(two ? {MW{1'b0}} : m3), m2, m1};
                    end
                    `OVSP_SRC_CH3: begin
                        sel = {{(2*MW){1'b0}}, (two ? mc3 : {MW{1'b0}})};
                    end
                    default: begin
                        sel = {{(2*MW){1'b0}}, mc4};
                    end
                endcase
            end

            assign single = src[1];

            // Three comparators sharing one level
            for (v = 0; v < 3; v = v + 1) begin : vlt
                ovsp_phase #(
                    .W        (MW)
                ) u_phase (
                    .i_clk    (I_CLK),
                    .i_rst_b  (I_RST_B),
                    .i_upd    (ph[1]),
                    .i_en     (~off),
                    .i_mag    (sel[v*MW +: MW]),
                    .i_level  (level),
                    .o_exceed (exc[v])
                );
            end

            // Count exceeding voltages against the required number
            assign cnt  = {1'b0, exc[0]} + {1'b0, exc[1]} + {1'b0, exc[2]};
            assign need = single ? 2'h1 : ((opm >= 2'h2) ? 2'h3 : (opm + 2'h1));
            assign pick_now = ~off && (cnt >= need);

            assign next_pick[g]  = pick_now;
            assign next_start[g] = forced ? (force_sel == `OVSP_FORCE_START) :
                                   (pick_now && !blk_mode);
            assign next_trip[g]  = forced && (force_sel == `OVSP_FORCE_TRIP);
            assign next_blk[g]   = forced ? (force_sel == `OVSP_FORCE_BLOCK) :
                                   (pick_now && blk_mode);
            assign next_test[g]  = (mode == `OVSP_MODE_TEST) || (mode == `OVSP_MODE_TESTBLK);

            assign sel_flat[g*3*MW +: 3*MW] = sel;
            assign lev_flat[g*MW +: MW]     = level;
        end
    endgenerate

    // Stage outputs registered one cycle after flags settle
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PICKUP  <= 4'h0;
            O_START   <= 4'h0;
            O_TRIP    <= 4'h0;
            O_BLOCKED <= 4'h0;
            O_TEST    <= 4'h0;
            pick_d    <= 4'h0;
            blk_d     <= 4'h0;
        end else begin
            pick_d <= O_PICKUP;
            blk_d  <= O_BLOCKED;
            if (ph[2]) begin
                O_PICKUP  <= next_pick;
                O_START   <= next_start;
                O_TRIP    <= next_trip;
                O_BLOCKED <= next_blk;
                O_TEST    <= next_test;
            end
        end
    end

    // Ratio operands for the current index
    assign rstage = (ridx >= 4'h9) ? 2'h3 : (ridx >= 4'h6) ? 2'h2 :
                    (ridx >= 4'h3) ? 2'h1 : 2'h0;
    assign rmag   = sel_flat[ridx*MW +: MW];
    assign rlev   = lev_flat[rstage*MW +: MW];
    assign rnum   = {{(24-MW){1'b0}}, rmag} * {17'h00000, `OVSP_PCT_FULL};

    ovsp_div #(
        .NW      (24),
        .DW      (MW)
    ) u_div (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_start (div_go),
        .i_num   (rnum),
        .i_den   (rlev),
        .o_done  (div_done),
        .o_quo   (div_quo)
    );

    // Walk all twelve voltages once per evaluation cycle
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ridx   <= 4'h0;
            rbusy  <= 1'b0;
            div_go <= 1'b0;
            for (i = 0; i < 12; i = i + 1) begin
                ratio[i] <= 17'h00000;
            end
        end else begin
            div_go <= 1'b0;
            if (ph[2] && !rbusy) begin
                ridx   <= 4'h0;
                rbusy  <= 1'b1;
                div_go <= 1'b1;
            end else if (rbusy && div_done) begin
                ratio[ridx] <= (div_quo > {7'h00, `OVSP_RATIO_MAX}) ?
                               `OVSP_RATIO_MAX : div_quo[16:0];
                if (ridx == RAT_LAST) begin
                    rbusy <= 1'b0;
                end else begin
                    ridx   <= ridx + 4'h1;
                    div_go <= 1'b1;
                end
            end
        end
    end

    // Address decode
    assign a      = {I_AVS_ADDRESS[7:2], 2'h0};
    assign blk    = I_AVS_ADDRESS[7:5];
    assign sdiff  = blk - `OVSP_STG_FIRST;
    assign s      = sdiff[1:0];
    assign w      = I_AVS_ADDRESS[4:2];
    assign is_stg = (blk >= `OVSP_STG_FIRST) && (blk <= `OVSP_STG_LAST);
    assign rix    = ({2'h0, s} * 4'h3) + {1'b0, w} - {1'b0, `OVSP_W_RAT_A};
    assign wr_acc = I_AVS_WRITE && O_AVS_WAITREQUEST;
    assign cfg_wm  = be_merge({25'h0000000, cfg[s]}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
    assign grp0_wm = be_merge({14'h0000, grp0[s]}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
    assign grp1_wm = be_merge({14'h0000, grp1[s]}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);

    // Read data selection
    always @* begin
        rd_next = 32'h00000000;
        if (is_stg) begin
            case (w)
                `OVSP_W_CFG:  rd_next = {25'h0000000, cfg[s]};
                `OVSP_W_GRP0: rd_next = {14'h0000, grp0[s]};
                `OVSP_W_GRP1: rd_next = {14'h0000, grp1[s]};
                default: begin
                    if (w <= `OVSP_W_RAT_C) begin
                        rd_next = {15'h0000, ratio[rix]};
                    end
                end
            endcase
        end else begin
            case (a)
                `OVSP_GCTRL:    rd_next = {28'h0000000, gctrl};
                `OVSP_STATUS:   rd_next = {12'h000, O_TEST, O_BLOCKED, O_TRIP, O_START, O_PICKUP};
                `OVSP_IRQ_STAT: rd_next = {24'h000000, irq_stat};
                `OVSP_IRQ_EN:   rd_next = {24'h000000, irq_en};
                default:        rd_next = 32'h00000000;
            endcase
        end
    end

    // Avalon slave: one wait cycle, then a single low waitrequest cycle
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA    <= 32'h00000000;
            gctrl             <= `OVSP_GCTRL_RST;
            irq_en            <= 8'h00;
            for (j = 0; j < 4; j = j + 1) begin
                cfg[j]  <= `OVSP_CFG_RST;
                grp0[j] <= `OVSP_GRP_RST;
                grp1[j] <= `OVSP_GRP_RST;
            end
        end else if ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST) begin
            O_AVS_WAITREQUEST <= 1'b0;
            O_AVS_READDATA    <= I_AVS_READ ? rd_next : 32'h00000000;
            if (wr_acc && is_stg) begin
                case (w)
                    `OVSP_W_CFG:  cfg[s]  <= cfg_wm[6:0];
                    `OVSP_W_GRP0: grp0[s] <= grp0_wm[17:0];
                    `OVSP_W_GRP1: grp1[s] <= grp1_wm[17:0];
                    default: begin
                        // Ratio words are read-only
                    end
                endcase
            end else if (wr_acc) begin
                case (a)
                    `OVSP_GCTRL: begin
                        if (I_AVS_BYTEENABLE[0]) begin
                            gctrl <= I_AVS_WRITEDATA[3:0];
                        end
                    end
                    `OVSP_IRQ_EN: begin
                        if (I_AVS_BYTEENABLE[0]) begin
                            irq_en <= I_AVS_WRITEDATA[7:0];
                        end
                    end
                    default: begin
                        // Unmapped or read-only: write ignored
                    end
                endcase
            end
        end else begin
            O_AVS_WAITREQUEST <= 1'b1;
        end
    end

    // Interrupt events: pick-up rise and blocked rise per stage
    assign ev_set   = {O_BLOCKED & ~blk_d, O_PICKUP & ~pick_d};
    assign clr_mask = (wr_acc && !is_stg && (a == `OVSP_IRQ_CLR) && I_AVS_BYTEENABLE[0]) ?
                      I_AVS_WRITEDATA[7:0] : 8'h00;
    assign next_irq_stat = (irq_stat & ~clr_mask) | ev_set;

    // Sticky status, new events win over a clear in the same cycle
    always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            irq_stat <= 8'h00;
            O_IRQ    <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            O_IRQ    <= |(next_irq_stat & irq_en);
        end
    end

endmodule

// File: ovsp_regs.vh
// Register map, field positions, codes, reset values and timing counts
// of the overvoltage stage pick-up block.
// Assumes byte addresses on the register bus and a 250 MHz clock.
`ifndef OVSP_REGS_VH
`define OVSP_REGS_VH

// Global registers, byte addresses
`define OVSP_GCTRL        8'h00
`define OVSP_STATUS       8'h04
`define OVSP_IRQ_STAT     8'h08
`define OVSP_IRQ_CLR      8'h0C
`define OVSP_IRQ_EN       8'h10

// Stage windows: address bits 7:5 select, stage n at 8'h40 + n * 8'h20
`define OVSP_STG_FIRST    3'h2
`define OVSP_STG_LAST     3'h5
// Word index inside a stage window
`define OVSP_W_CFG        3'h0
`define OVSP_W_GRP0       3'h1
`define OVSP_W_GRP1       3'h2
`define OVSP_W_RAT_A      3'h3
`define OVSP_W_RAT_C      3'h5

// Global control bits
`define OVSP_G_ALLOW_MODE 0
`define OVSP_G_FORCE_EN   1
`define OVSP_G_TWO_LINE   2
`define OVSP_G_GROUP      3

// Stage configuration fields (static, not per group)
`define OVSP_C_MODE_LSB   0
`define OVSP_C_FORCE_LSB  3
`define OVSP_C_SRC_LSB    5
// Group fields: level in 0.01 %Un, operation mode
`define OVSP_P_LEVEL_LSB  0
`define OVSP_P_OPM_LSB    16

// Node behaviour modes
`define OVSP_MODE_ON      3'h0
`define OVSP_MODE_BLOCKED 3'h1
`define OVSP_MODE_TEST    3'h2
`define OVSP_MODE_TESTBLK 3'h3
`define OVSP_MODE_OFF     3'h4
// Forced status
`define OVSP_FORCE_NORMAL 2'h0
`define OVSP_FORCE_START  2'h1
`define OVSP_FORCE_TRIP   2'h2
`define OVSP_FORCE_BLOCK  2'h3
// Supervised source
`define OVSP_SRC_PP       2'h0
`define OVSP_SRC_PE       2'h1
`define OVSP_SRC_CH3      2'h2
`define OVSP_SRC_CH4      2'h3

// Reset values: mode On, force Normal, phase-to-phase, 105.00 %, 1 voltage
`define OVSP_GCTRL_RST    4'h0
`define OVSP_CFG_RST      7'h00
`define OVSP_GRP_RST      18'h02904

// Hysteresis and ratio scaling
`define OVSP_PCT_FULL     7'h64
`define OVSP_PCT_RESET    7'h61
`define OVSP_RATIO_MAX    17'h1E848

// Evaluation period
`define OVSP_TICK_US      5000
`define OVSP_CLK_MHZ      250

`endif

// File: ovsp_phase.v
// One supervised voltage: exceed flag with fixed reset-ratio hysteresis.
// Assumes magnitude and level in the same 0.01 %Un units, same clock.
`timescale 1ns/10ps
`include "ovsp_regs.vh"

module ovsp_phase #(
    parameter W = 16
) (
    input  wire         i_clk,    // System clock
    input  wire         i_rst_b,  // Async reset, active low
    input  wire         i_upd,    // Evaluation pulse
    input  wire         i_en,     // Stage enabled
    input  wire [W-1:0] i_mag,    // Measured magnitude
    input  wire [W-1:0] i_level,  // Common pick-up level
    output reg          o_exceed  // Voltage above level
);

    wire [W+6:0] mag_x;
    wire [W+6:0] rel_x;

    // Scaled values for the release comparison
    assign mag_x = {7'h00, i_mag} * {{W{1'b0}}, `OVSP_PCT_FULL};
    assign rel_x = {7'h00, i_level} * {{W{1'b0}}, `OVSP_PCT_RESET};

    // Set above level, clear below 97 % of level, once per cycle
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_exceed <= 1'b0;
        end else if (i_upd) begin
            if (!i_en) begin
                o_exceed <= 1'b0;
            end else if (!o_exceed && (i_mag > i_level)) begin
                o_exceed <= 1'b1;
            end else if (o_exceed && (mag_x < rel_x)) begin
                o_exceed <= 1'b0;
            end
        end
    end

endmodule

// File: ovsp_div.v
// Sequential restoring divider, one quotient bit per clock.
// Assumes a start pulse only while idle; divide by zero gives all ones.
`timescale 1ns/10ps

module ovsp_div #(
    parameter NW = 24,
    parameter DW = 16
) (
    input  wire          i_clk,   // System clock
    input  wire          i_rst_b, // Async reset, active low
    input  wire          i_start, // Start pulse
    input  wire [NW-1:0] i_num,   // Dividend
    input  wire [DW-1:0] i_den,   // Divisor
    output reg           o_done,  // Quotient ready pulse
    output wire [NW-1:0] o_quo    // Quotient
);

    localparam [5:0] NSTEP = NW;

    reg  [DW:0]   rem;
    reg  [NW-1:0] num;
    reg  [DW-1:0] den;
    reg  [5:0]    cnt;
    reg           busy;
    wire [DW:0]   trial;
    wire          fits;

    // Partial remainder with next dividend bit
    assign trial = {rem[DW-1:0], num[NW-1]};
    assign fits  = (trial >= {1'b0, den});
    assign o_quo = num;

    // Shift quotient bits into the dividend register
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rem    <= {(DW+1){1'b0}};
            num    <= {NW{1'b0}};
            den    <= {DW{1'b0}};
            cnt    <= 6'h00;
            busy   <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                rem  <= {(DW+1){1'b0}};
                num  <= i_num;
                den  <= i_den;
                cnt  <= NSTEP;
                busy <= 1'b1;
            end else if (busy) begin
                rem <= fits ? (trial - {1'b0, den}) : trial;
                num <= {num[NW-2:0], fits};
                cnt <= cnt - 6'h01;
                if (cnt == 6'h01) begin
                    busy   <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

endmodule

// File: ovsp_top_sva.sv
// Checker on the ports of the pick-up block top
// Bound into ovsp_top below; one clock, async low reset
`timescale 1ns/10ps
module ovsp_sva #(
    parameter TICK_CYCLES = 64
) (
    input wire logic        I_CLK, I_RST_B, I_AVS_READ, I_AVS_WRITE,
    input wire logic        O_AVS_WAITREQUEST, O_IRQ,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic [3:0]  O_PICKUP, O_START, O_TRIP, O_BLOCKED
);
    int ph;
    // Position inside the evaluation period
    always_ff @(posedge I_CLK or negedge I_RST_B)
        if (!I_RST_B) ph <= 0;
        else ph <= (ph == TICK_CYCLES - 1) ? 0 : ph + 1;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    property p_one; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
    a_one: assert property (p_one) else $error("wait low twice");
    property p_ans; (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_why; $fell(O_AVS_WAITREQUEST) |-> $past(I_AVS_READ) || $past(I_AVS_WRITE); endproperty
    a_why: assert property (p_why) else $error("answer without request");
    property p_wr0; $fell(O_AVS_WAITREQUEST) && $past(I_AVS_WRITE) |-> O_AVS_READDATA == 32'h0; endproperty
    a_wr0: assert property (p_wr0) else $error("write answer not zero");
    property p_rst; $rose(I_RST_B) |-> O_PICKUP == 4'h0 && !O_IRQ && O_AVS_WAITREQUEST; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_pk; !$stable(O_PICKUP) |-> ph < 8; endproperty
    a_pk: assert property (p_pk) else $error("pick-up off tick");
    property p_out; !$stable({O_START, O_BLOCKED, O_TRIP}) |-> ph < 8; endproperty
    a_out: assert property (p_out) else $error("status off tick");
    property p_ex; (O_START & O_BLOCKED) == 4'h0; endproperty
    a_ex: assert property (p_ex) else $error("start and blocked");
    cover property ($rose(O_PICKUP[0]));
    cover property ($rose(O_BLOCKED[1]));
    cover property ($rose(O_TRIP[2]));
endmodule
bind ovsp_top ovsp_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);

// File: testbench.sv
// Self-checking bench for the overvoltage stage pick-up block
// Drives the Avalon-MM slave and all magnitudes; short period
`timescale 1ns/10ps
module testbench;
    localparam TK = 64;
    logic        I_CLK = 0, I_RST_B = 0, I_AVS_READ = 0, I_AVS_WRITE = 0, O_AVS_WAITREQUEST, O_IRQ;
    logic [7:0]  I_AVS_ADDRESS = 0;
    logic [3:0]  I_AVS_BYTEENABLE = 4'hF, O_PICKUP, O_START, O_TRIP, O_BLOCKED, O_TEST;
    logic [31:0] I_AVS_WRITEDATA = 0, O_AVS_READDATA, rd;
    logic [15:0] v [8] = '{default: 16'h0};
    int          err_total = 0, check_count = 0;
    // 250 MHz clock
    always #2 I_CLK = ~I_CLK;
    ovsp_top #(.TICK_CYCLES(TK)) dut (.I_UL12(v[0]), .I_UL23(v[1]), .I_UL31(v[2]), .I_UL1(v[3]),
        .I_UL2(v[4]), .I_UL3(v[5]), .I_UCH3(v[6]), .I_UCH4(v[7]), .*);
    task automatic chk(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One access, held until waitrequest is sampled low
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_AVS_ADDRESS <= a;
        I_AVS_WRITEDATA <= d;
        I_AVS_WRITE <= w;
        I_AVS_READ <= !w;
        do @(posedge I_CLK); while (O_AVS_WAITREQUEST !== 1'b0);
        rd = O_AVS_READDATA;
        I_AVS_WRITE <= 1'b0;
        I_AVS_READ <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(0, a, 0);
        chk(rd, e);
    endtask
    task automatic wt();
        repeat (TK + 8) @(posedge I_CLK);
    endtask
    task automatic setv(input logic [15:0] x);
        foreach (v[i]) v[i] <= x;
    endtask
    task automatic t_defaults();
        rdc(8'h44, 32'h02904);
        rdc(8'h48, 32'h02904);
        rdc(8'h40, 32'h0);
        rdc(8'h20, 32'h0);
    endtask
    // Level edge, hold at exactly 97 percent, release just below
    task automatic t_hyst();
        logic [15:0] m [4] = '{16'h2905, 16'h27C9, 16'h27C8, 16'h2904};
        logic [7:0] e [4] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) begin
            setv(m[i]);
            wt();
            rdc(8'h04, {24'h0, e[i]});
            if (i == 0) repeat (6) wt();
            if (i == 0) rdc(8'h4C, 32'h64);
        end
    endtask
    // Two voltages high under each operation mode, then group swap
    task automatic t_opmode();
        for (int i = 0; i < 8; i++) v[i] <= (i < 2) ? 16'h2905 : 16'h0;
        for (int m = 0; m < 3; m++) begin
            bus(1, 8'h44, {14'h0, m[1:0], 16'h2904});
            wt();
            rdc(8'h04, {24'h0, 4'hE | (m < 2), 4'hE | (m < 2)});
        end
        bus(1, 8'h00, 32'h8);
        wt();
        rdc(8'h04, 32'hFF);
        rdc(8'h40, 32'h0);
        bus(1, 8'h00, 32'h0);
        bus(1, 8'h44, 32'h02904);
    endtask
    // Every source of stage 0; phase-to-phase and channel 3 with and without two-line connection
    task automatic t_source();
        logic [7:0] c [6] = '{8'h00, 8'h20, 8'h40, 8'h40, 8'h00, 8'h60};
        int ch [6] = '{0, 3, 6, 6, 2, 7};
        logic [3:0] e [6] = '{4'hF, 4'h1, 4'h0, 4'h1, 4'h0, 4'h1};
        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 8; k++) v[k] <= (k == ch[i]) ? 16'h2905 : 16'h0;
            bus(1, 8'h00, (i == 3 || i == 4) ? 32'h4 : 32'h0);
            bus(1, 8'h40, {24'h0, c[i]});
            wt();
            rdc(8'h04, {24'h0, e[i], e[i]});
        end
        bus(1, 8'h40, 32'h0);
        setv(16'h0);
        wt();
    endtask
    // Blocked stage raises, masks and clears the interrupt
    task automatic t_irq();
        bus(1, 8'h0C, 32'hFF);
        bus(1, 8'h10, 32'h20);
        bus(1, 8'h00, 32'h1);
        bus(1, 8'h60, 32'h1);
        setv(16'h2905);
        wt();
        chk(O_BLOCKED, 4'h2);
        chk(O_START, 4'hD);
        rdc(8'h08, 32'h2F);
        chk(O_IRQ, 1'b1);
        bus(1, 8'h10, 32'h0);
        rdc(8'h08, 32'h2F);
        chk(O_IRQ, 1'b0);
        bus(1, 8'h10, 32'h20);
        bus(1, 8'h0C, 32'h20);
        rdc(8'h08, 32'h0F);
        chk(O_IRQ, 1'b0);
    endtask
    // Forced status needs the global enable
    task automatic t_force();
        setv(16'h0);
        bus(1, 8'h60, 32'h0);
        bus(1, 8'h80, 32'h10);
        wt();
        chk(O_TRIP, 4'h0);
        bus(1, 8'h00, 32'h2);
        wt();
        chk(O_TRIP, 4'h4);
        bus(1, 8'h80, 32'h08);
        wt();
        chk(O_START, 4'h4);
        bus(1, 8'h00, 32'h3);
        bus(1, 8'hA0, 32'h3);
        bus(1, 8'h40, 32'h4);
        setv(16'h2905);
        wt();
        chk(O_TEST, 4'h8);
        chk(O_PICKUP, 4'hE);
        chk(O_BLOCKED, 4'h8);
    endtask
    task automatic end_sim();
        $display("mismatches %0d, checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge I_CLK);
        I_RST_B <= 1'b1;
        t_defaults();
        t_hyst();
        t_opmode();
        t_source();
        t_irq();
        t_force();
        end_sim();
    end
    // Watchdog
    initial begin
        #100000;
        err_total++;
        end_sim();
    end
endmodule
